// ### hw/cpx_exec.sv
// Execution unit for mode, return jump, block copy, exchange and counter read.
`timescale 1ns/100ps
`include "cpx_params.svh"
module cpx_exec (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// Register port.
	input  wire logic [3:0]       reg_addr_i,
	input  wire logic [31:0]      reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [31:0]      reg_rdata_o,
	// Instruction issue and operands.
	input  wire logic             instr_valid_i,
	input  wire logic [59:0]      instr_word_i,
	input  wire logic [1:0]       parcel_i,
	input  wire logic [17:0]      p_addr_i,
	input  wire logic [17:0]      index_reg_j_i,
	input  wire logic [59:0]      operand_reg_k_i,
	input  wire logic [59:0]      operand_reg_j_i,
	input  wire logic [59:0]      operand_reg_zero_i,
	input  wire logic [17:0]      address_reg_zero_i,
	input  wire logic [23:0]      central_reference_address_i,
	input  wire logic [23:0]      extended_reference_address_i,
	input  wire logic [23:0]      extended_field_length_i,
	input  wire logic [23:0]      monitor_exchange_address_i,
	input  wire logic             abort_i,
	input  wire logic             ext_xchg_i,
	output logic                  busy_o,
	output logic                  mode_monitor_flag_o,
	// Completion and write back.
	output logic                  done_o,
	output logic      [17:0]      next_p_o,
	output logic      [1:0]       next_parcel_o,
	output logic                  wb_valid_o,
	output logic      [2:0]       wb_idx_o,
	output logic      [59:0]      wb_data_o,
	output logic                  err_valid_o,
	output cpx_pkg::cpx_err_t     err_code_o,
	// Memory port.
	output logic                  mem_req_o,
	output logic                  mem_we_o,
	output logic                  mem_ext_o,
	output logic      [23:0]      mem_addr_o,
	output logic      [59:0]      mem_wdata_o,
	input  wire logic             mem_ack_i,
	input  wire logic [59:0]      mem_rdata_i,
	// Exchange port.
	output logic                  xchg_req_o,
	output logic      [23:0]      xchg_addr_o,
	output logic      [17:0]      xchg_save_p_o,
	input  wire logic             xchg_ack_i,
	input  wire logic [17:0]      xchg_p_i
);
	import cpx_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [14:0] parcel_of(input logic [59:0] w, input logic [1:0] idx);
		parcel_of = w[59 - 15*idx -: 15];
	endfunction

	function automatic logic [17:0] oc_add(input logic [17:0] a, input logic [17:0] b);
		logic [18:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add = s[17:0] + {17'h0_0000, s[18]};
	endfunction

	function automatic logic [19:0] step_parcel(input logic [17:0] p, input logic [1:0] pc);
		step_parcel = (pc == 2'h3) ? {p + 18'h0_0001, 2'h0} : {p, pc + 2'h1};
	endfunction

	function automatic cpx_err_t err_for(input logic mf);
		err_for = mf ? CPX_ERR_VIRTUAL : CPX_ERR_ILLEGAL;
	endfunction

	typedef struct packed {
		cpx_state_t st;
		logic       mf;
		logic [47:0] ctr;
		logic [3:0] ctrl;
		logic [17:0] rem;
		logic [23:0] src;
		logic [23:0] dst;
		logic       to_ext;
		logic       zfill;
		logic [17:0] p_cur;
		logic [17:0] tgt_p;
		logic [1:0] tgt_pc;
		logic       mem_req;
		logic       mem_we;
		logic       mem_ext;
		logic [23:0] mem_addr;
		logic [59:0] mem_wdata;
		logic       done;
		logic [17:0] next_p;
		logic [1:0] next_pc;
		logic       wb_valid;
		logic [2:0] wb_idx;
		logic [59:0] wb_data;
		logic       err_valid;
		cpx_err_t   err_code;
		logic       xchg_req;
		logic [23:0] xchg_addr;
		logic [17:0] xchg_save_p;
		logic [31:0] rdata;
	} cpx_regs_t;

	cpx_regs_t s_reg;
	cpx_regs_t s_next;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [14:0] pa;
	logic [14:0] pb;
	logic [8:0]  op9;
	logic [17:0] kval;
	logic [17:0] cnt;
	logic [23:0] ext_start;
	logic [23:0] cm_start;
	logic [23:0] ext_off;
	logic [19:0] nx;
	logic        take;
	logic        cnt_zero;
	logic        cnt_neg;
	logic        blk_bad;
	logic        ext_en;

	// Unused designator bits are simply never looked at.
	assign pa        = parcel_of(instr_word_i, parcel_i);
	assign pb        = parcel_of(instr_word_i, parcel_i + 2'h1);
	assign op9       = pa[14:6];
	assign kval      = {pa[2:0], pb};
	assign cnt       = oc_add(index_reg_j_i, kval);
	assign cnt_zero  = (cnt == 18'h0_0000) || (cnt == 18'h3_FFFF);
	assign cnt_neg   = cnt[17] && !cnt_zero;
	assign ext_start = operand_reg_zero_i[23:0] + extended_reference_address_i;
	assign ext_off   = operand_reg_k_i[23:0] + extended_reference_address_i;
	// Bits 51 to 59 of operand zero are left to software to keep clear.
	assign cm_start  = (s_reg.ctrl[`CPX_CTRL_BCF] ? {3'h0, operand_reg_zero_i[50:30]}
		: {6'h00, address_reg_zero_i}) + central_reference_address_i;
	assign nx        = step_parcel(p_addr_i, parcel_i);
	assign take      = instr_valid_i && (s_reg.st == CPX_IDLE);
	assign ext_en    = s_reg.ctrl[`CPX_CTRL_EXT_EN];
	assign blk_bad   = (parcel_i != 2'h0) || !ext_en;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next           = s_reg;
		s_next.ctr       = s_reg.ctr + 48'h0000_0000_0001;
		s_next.done      = 1'b0;
		s_next.wb_valid  = 1'b0;
		s_next.err_valid = 1'b0;
		s_next.rdata     = 32'h0000_0000;
		if (reg_wr_i && reg_addr_i == `CPX_REG_CTRL) begin
			s_next.ctrl = reg_wdata_i[3:0];
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`CPX_REG_CTRL: s_next.rdata = {28'h000_0000, s_reg.ctrl};
				`CPX_REG_STATUS: s_next.rdata = {30'h0000_0000, s_reg.st != CPX_IDLE, s_reg.mf};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
		// Peripheral or error exchanges completed elsewhere also flip the mode, except in a cycle where xchg_ack_i ends this unit's own exchange.
		if (ext_xchg_i) begin
			s_next.mf = !s_reg.mf;
		end
		case (s_reg.st)
			CPX_IDLE: begin
				if (take) begin
					s_next.p_cur  = p_addr_i;
					s_next.wb_idx = pa[5:3];
					s_next.done   = 1'b1;
					s_next.next_p = nx[19:2];
					s_next.next_pc = nx[1:0];
					if (pa[14:9] == `CPX_OP_ILLEGAL) begin
						// A suppressed exit lets the parcel pass untouched.
						if (s_reg.ctrl[`CPX_CTRL_ILL_EN]) begin
							s_next.done      = 1'b0;
							s_next.err_valid = 1'b1;
							s_next.err_code  = err_for(s_reg.mf);
						end
					end else begin
						case (op9)
							`CPX_OP_LINK: begin
								s_next.done      = 1'b0;
								s_next.st        = CPX_SWR;
								s_next.mem_req   = 1'b1;
								s_next.mem_we    = 1'b1;
								s_next.mem_ext   = 1'b0;
								s_next.mem_addr  = {6'h00, kval} + central_reference_address_i;
								s_next.mem_wdata = {`CPX_JUMP_OPCODE, p_addr_i + 18'h0_0001,
									30'h0000_0000};
								s_next.tgt_p     = kval + 18'h0_0001;
								s_next.tgt_pc    = 2'h0;
							end
							`CPX_OP_BLK_RD, `CPX_OP_BLK_WR: begin
								s_next.to_ext = (op9 == `CPX_OP_BLK_WR);
								s_next.zfill  = ext_start[21] || ext_start[22];
								s_next.rem    = cnt;
								s_next.src    = (op9 == `CPX_OP_BLK_WR) ? cm_start : ext_start;
								s_next.dst    = (op9 == `CPX_OP_BLK_WR) ? ext_start : cm_start;
								s_next.tgt_p  = (ext_start[21] || ext_start[22]) ? p_addr_i
									: p_addr_i + 18'h0_0001;
								s_next.tgt_pc = (ext_start[21] || ext_start[22])
									? `CPX_PARCEL_RESUME : 2'h0;
								s_next.next_p  = p_addr_i + 18'h0_0001;
								s_next.next_pc = 2'h0;
								if (blk_bad || cnt_neg) begin
									s_next.done = 1'b0;
									if (blk_bad && s_reg.ctrl[`CPX_CTRL_ILL_EN]) begin
										s_next.err_valid = 1'b1;
										s_next.err_code  = err_for(s_reg.mf);
									end else if (!blk_bad && s_reg.ctrl[`CPX_CTRL_RNG_EN]) begin
										s_next.err_valid = 1'b1;
										s_next.err_code  = CPX_ERR_RANGE;
									end else begin
										s_next.done = 1'b1;
									end
								end else if (!cnt_zero) begin
									s_next.done = 1'b0;
									if (ext_start[21] || ext_start[22]) begin
										if (op9 == `CPX_OP_BLK_RD) begin
											s_next.st        = CPX_CWR;
											s_next.mem_req   = 1'b1;
											s_next.mem_we    = 1'b1;
											s_next.mem_ext   = 1'b0;
											s_next.mem_addr  = cm_start;
											s_next.mem_wdata = 60'h0;
										end else begin
											s_next.done    = 1'b1;
											s_next.next_p  = p_addr_i;
											s_next.next_pc = `CPX_PARCEL_RESUME;
										end
									end else begin
										s_next.st       = CPX_CRD;
										s_next.mem_req  = 1'b1;
										s_next.mem_we   = 1'b0;
										s_next.mem_ext  = (op9 == `CPX_OP_BLK_RD);
										s_next.mem_addr = (op9 == `CPX_OP_BLK_WR) ? cm_start : ext_start;
									end
								end
							end
							`CPX_OP_XCHG: begin
								s_next.done = 1'b0;
								if (parcel_i != 2'h0) begin
									s_next.err_valid = s_reg.ctrl[`CPX_CTRL_ILL_EN];
									s_next.err_code  = err_for(s_reg.mf);
									s_next.done      = !s_reg.ctrl[`CPX_CTRL_ILL_EN];
								end else begin
									s_next.st          = CPX_XCH;
									s_next.xchg_req    = 1'b1;
									s_next.xchg_save_p = p_addr_i + 18'h0_0001;
									s_next.xchg_addr   = s_reg.mf ? {6'h00, cnt}
										: monitor_exchange_address_i;
								end
							end
							`CPX_OP_EXT_RD, `CPX_OP_EXT_WR: begin
								s_next.done = 1'b0;
								if (!ext_en) begin
									s_next.err_valid = s_reg.ctrl[`CPX_CTRL_ILL_EN];
									s_next.err_code  = err_for(s_reg.mf);
									s_next.done      = !s_reg.ctrl[`CPX_CTRL_ILL_EN];
								end else if (operand_reg_k_i[23:0] >= extended_field_length_i
									|| operand_reg_k_i[59:24] != 36'h0) begin
									s_next.err_valid = s_reg.ctrl[`CPX_CTRL_RNG_EN];
									s_next.err_code  = CPX_ERR_RANGE;
									s_next.done      = !s_reg.ctrl[`CPX_CTRL_RNG_EN];
								end else begin
									s_next.st        = (op9 == `CPX_OP_EXT_RD) ? CPX_SRD : CPX_SWR;
									s_next.mem_req   = 1'b1;
									s_next.mem_we    = (op9 == `CPX_OP_EXT_WR);
									s_next.mem_ext   = 1'b1;
									s_next.mem_addr  = ext_off;
									s_next.mem_wdata = operand_reg_j_i;
									s_next.tgt_p     = nx[19:2];
									s_next.tgt_pc    = nx[1:0];
								end
							end
							`CPX_OP_CTR_RD: begin
								s_next.wb_valid = 1'b1;
								s_next.wb_data  = {12'h000, s_reg.ctr};
							end
							default: begin
								s_next.done = 1'b1;
							end
						endcase
					end
				end
			end
			CPX_CRD, CPX_CWR: begin
				if (mem_ack_i) begin
					s_next.mem_req = 1'b0;
					if (s_reg.st == CPX_CRD) begin
						s_next.st        = CPX_CWR;
						s_next.mem_req   = 1'b1;
						s_next.mem_we    = 1'b1;
						s_next.mem_ext   = s_reg.to_ext;
						s_next.mem_addr  = s_reg.dst;
						s_next.mem_wdata = mem_rdata_i;
					end else if (s_reg.rem == 18'h0_0001) begin
						s_next.st      = CPX_IDLE;
						s_next.done    = 1'b1;
						s_next.next_p  = s_reg.tgt_p;
						s_next.next_pc = s_reg.tgt_pc;
					end else begin
						s_next.rem = s_reg.rem - 18'h0_0001;
						s_next.src = s_reg.src + 24'h00_0001;
						s_next.dst = s_reg.dst + 24'h00_0001;
						s_next.mem_req = 1'b1;
						if (s_reg.zfill) begin
							s_next.mem_addr = s_reg.dst + 24'h00_0001;
						end else begin
							s_next.st       = CPX_CRD;
							s_next.mem_we   = 1'b0;
							s_next.mem_ext  = !s_reg.to_ext;
							s_next.mem_addr = s_reg.src + 24'h00_0001;
						end
					end
				end else if (abort_i) begin
					// Partial progress is discarded; the word is reissued.
					s_next.st      = CPX_IDLE;
					s_next.mem_req = 1'b0;
					s_next.done    = 1'b1;
					s_next.next_p  = s_reg.p_cur;
					s_next.next_pc = 2'h0;
				end
			end
			CPX_SRD, CPX_SWR: begin
				if (mem_ack_i) begin
					s_next.st       = CPX_IDLE;
					s_next.mem_req  = 1'b0;
					s_next.done     = 1'b1;
					s_next.next_p   = s_reg.tgt_p;
					s_next.next_pc  = s_reg.tgt_pc;
					s_next.wb_valid = (s_reg.st == CPX_SRD);
					s_next.wb_data  = mem_rdata_i;
				end
			end
			CPX_XCH: begin
				if (xchg_ack_i) begin
					s_next.st       = CPX_IDLE;
					s_next.xchg_req = 1'b0;
					s_next.mf       = !s_reg.mf;
					s_next.done     = 1'b1;
					s_next.next_p   = xchg_p_i;
					s_next.next_pc  = 2'h0;
				end
			end
			default: begin
				s_next.st = CPX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_reg      <= '0;
			s_reg.st   <= CPX_IDLE;
			s_reg.mf   <= `CPX_MF_RST;
			s_reg.ctrl <= `CPX_CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata_o         = s_reg.rdata;
	assign busy_o              = s_reg.st != CPX_IDLE;
	assign mode_monitor_flag_o = s_reg.mf;
	assign done_o              = s_reg.done;
	assign next_p_o            = s_reg.next_p;
	assign next_parcel_o       = s_reg.next_pc;
	assign wb_valid_o          = s_reg.wb_valid;
	assign wb_idx_o            = s_reg.wb_idx;
	assign wb_data_o           = s_reg.wb_data;
	assign err_valid_o         = s_reg.err_valid;
	assign err_code_o          = s_reg.err_code;
	assign mem_req_o           = s_reg.mem_req;
	assign mem_we_o            = s_reg.mem_we;
	assign mem_ext_o           = s_reg.mem_ext;
	assign mem_addr_o          = s_reg.mem_addr;
	assign mem_wdata_o         = s_reg.mem_wdata;
	assign xchg_req_o          = s_reg.xchg_req;
	assign xchg_addr_o         = s_reg.xchg_addr;
	assign xchg_save_p_o       = s_reg.xchg_save_p;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence rd_ack_s;
		s_reg.st == CPX_CRD && mem_ack_i;
	endsequence
	sequence wr_issue_s;
		s_reg.mem_req && s_reg.mem_we && s_reg.mem_addr == $past(s_reg.dst);
	endsequence

	// The first edge after reset sees the reset value twice, so it is left out.
	counter_step_a: assert property (
		!$past(srst_i) |-> s_reg.ctr == $past(s_reg.ctr) + 48'h0000_0000_0001
	) else $error("counter did not step");
	mode_cause_a: assert property ($changed(s_reg.mf) |-> $past(xchg_ack_i || ext_xchg_i)) else $error("mode changed without exchange");
	mode_toggle_a: assert property (s_reg.st == CPX_XCH && xchg_ack_i && !ext_xchg_i |=> s_reg.mf != $past(s_reg.mf) && s_reg.done && s_reg.next_pc == 2'h0) else $error("exchange did not toggle mode");
	ctr_read_a: assert property (take && pa[14:9] != 6'h00 && op9 == `CPX_OP_CTR_RD |=> s_reg.wb_valid && s_reg.wb_data[59:48] == 12'h000) else $error("counter read wrong");
	link_word_a: assert property (take && op9 == `CPX_OP_LINK |=> s_reg.mem_we && s_reg.mem_wdata[29:0] == 30'h0000_0000 && s_reg.mem_wdata[59:48] == `CPX_JUMP_OPCODE) else $error("link word wrong");
	illegal_op_a: assert property (take && pa[14:9] == `CPX_OP_ILLEGAL && s_reg.ctrl[`CPX_CTRL_ILL_EN] |=> s_reg.err_valid && !s_reg.done) else $error("opcode 00 not trapped");
	copy_place_a: assert property (take && (op9 == `CPX_OP_BLK_RD || op9 == `CPX_OP_BLK_WR) && blk_bad && s_reg.ctrl[`CPX_CTRL_ILL_EN] |=> s_reg.err_valid && s_reg.st == CPX_IDLE) else $error("illegal copy accepted");
	copy_pass_a: assert property (take && (op9 == `CPX_OP_BLK_RD || op9 == `CPX_OP_BLK_WR) && !blk_bad && cnt_zero |=> s_reg.done && s_reg.next_pc == 2'h0 && !s_reg.mem_req) else $error("zero count not a pass");
	copy_step_a: assert property (rd_ack_s |=> wr_issue_s) else $error("copy write not issued");
	xchg_addr_a: assert property (take && op9 == `CPX_OP_XCHG && parcel_i == 2'h0 && !s_reg.mf |=> s_reg.xchg_req && s_reg.xchg_addr == $past(monitor_exchange_address_i)) else $error("exchange address wrong");
endmodule

// ### hw/cpx_params.svh
// Constants for the central processor control and block copy execution unit.
`ifndef CPX_PARAMS_SVH
`define CPX_PARAMS_SVH
`define CPX_OP_ILLEGAL   6'h00
`define CPX_OP_LINK      9'h008
`define CPX_OP_BLK_RD    9'h009
`define CPX_OP_BLK_WR    9'h00A
`define CPX_OP_XCHG      9'h00B
`define CPX_OP_EXT_RD    9'h00C
`define CPX_OP_EXT_WR    9'h00D
`define CPX_OP_CTR_RD    9'h00E
`define CPX_JUMP_OPCODE  12'h100
`define CPX_MF_RST       1'b1
`define CPX_REG_CTRL     4'h0
`define CPX_REG_STATUS   4'h4
`define CPX_CTRL_RST     4'h0
`define CPX_CTRL_EXT_EN  0
`define CPX_CTRL_BCF     1
`define CPX_CTRL_ILL_EN  2
`define CPX_CTRL_RNG_EN  3
`define CPX_PARCEL_RESUME 2'h2
`endif

// ### hw/cpx_pkg.sv
// Types shared by the control and block copy execution unit.
package cpx_pkg;
	typedef enum logic [5:0] {
		CPX_IDLE = 6'h01,
		CPX_CRD  = 6'h02,
		CPX_CWR  = 6'h04,
		CPX_SRD  = 6'h08,
		CPX_SWR  = 6'h10,
		CPX_XCH  = 6'h20
	} cpx_state_t;
	typedef enum logic [1:0] {
		CPX_ERR_ILLEGAL = 2'h0,
		CPX_ERR_VIRTUAL = 2'h1,
		CPX_ERR_RANGE   = 2'h2
	} cpx_err_t;
endpackage

// ### testbench/cpx_mem_model.sv
// Behavioural central and extended memory with an exchange responder.
`timescale 1ns/100ps
module cpx_mem_model (
	// Clock and requests.
	input  wire logic        clk_i,
	input  wire logic        mem_req_i,
	input  wire logic        mem_we_i,
	input  wire logic        mem_ext_i,
	input  wire logic [23:0] mem_addr_i,
	input  wire logic [59:0] mem_wdata_i,
	input  wire logic        xchg_req_i,
	// Answers.
	output logic             mem_ack_o = 1'b0,
	output logic      [59:0] mem_rdata_o = 60'h0,
	output logic             xchg_ack_o = 1'b0,
	output logic      [17:0] xchg_p_o = 18'h0
);
	logic [59:0] cmem [int];
	logic [59:0] emem [int];
	int          lat = 1;
	int          cnt = 0;
	logic [17:0] new_p = 18'h0;
	// Released data lines toggle so a stale value is never mistaken for an answer.
	always @(posedge clk_i) begin
		mem_ack_o <= 1'b0;
		xchg_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		xchg_p_o <= ~xchg_p_o;
		if (mem_ack_o || xchg_ack_o) begin
			cnt <= 0;
		end else if ((mem_req_i || xchg_req_i) && cnt < lat) begin
			cnt <= cnt + 1;
		end else if (xchg_req_i) begin
			xchg_ack_o <= 1'b1;
			xchg_p_o <= new_p;
		end else if (mem_req_i) begin
			mem_ack_o <= 1'b1;
			if (mem_we_i && mem_ext_i) begin
				emem[mem_addr_i] = mem_wdata_i;
			end else if (mem_we_i) begin
				cmem[mem_addr_i] = mem_wdata_i;
			end else if (mem_ext_i) begin
				mem_rdata_o <= emem.exists(mem_addr_i) ? emem[mem_addr_i] : 60'h0;
			end else begin
				mem_rdata_o <= cmem.exists(mem_addr_i) ? cmem[mem_addr_i] : 60'h0;
			end
		end
	end
endmodule

// ### testbench/cp_control_and_block_copy_ops_tb.sv
// Self-checking bench for the control and block copy execution unit.
`timescale 1ns/100ps
module cp_control_and_block_copy_ops_tb;
	import cpx_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
	logic        clk = 1'b0, srst = 1'b1, rwr = 1'b0, rrd = 1'b0, iv = 1'b0;
	logic        abort = 1'b0, exx = 1'b0, busy, mf, done, wbv, errv;
	logic        mreq, mwe, mext, mack, xreq, xack;
	logic [3:0]  radr = 4'h0;
	logic [31:0] rwd = 32'h0, rdata, rv;
	logic [59:0] iw = 60'h0, xk = 60'h0, xj = 60'h0, x0 = 60'h0, wbd, mwd, mrd, c1;
	logic [1:0]  par = 2'd0, npar;
	logic [17:0] pa = 18'h0_0100, bj = 18'h0, a0 = 18'h0_0300, np, xsp, xp, xs;
	logic [23:0] central_reference_address = 24'h00_1000, extended_reference_address = 24'h01_0000, extended_field_length = 24'h00_1000;
	logic [23:0] mxa = 24'h00_0ABC, madr, xadr, xa;
	logic [2:0]  wbi, hit;
	cpx_err_t    errc;
	int          fail_count = 0, checks = 0, cyc = 0, t0, t1;
	initial forever #2 clk = ~clk;
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (xreq) begin
			xa <= xadr;
			xs <= xsp;
		end
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	cpx_exec DUT (.clk_i(clk), .srst_i(srst), .reg_addr_i(radr), .reg_wdata_i(rwd),
		.reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata), .instr_valid_i(iv),
		.instr_word_i(iw), .parcel_i(par), .p_addr_i(pa), .index_reg_j_i(bj),
		.operand_reg_k_i(xk), .operand_reg_j_i(xj), .operand_reg_zero_i(x0),
		.address_reg_zero_i(a0), .central_reference_address_i(central_reference_address),
		.extended_reference_address_i(extended_reference_address), .extended_field_length_i(extended_field_length),
		.monitor_exchange_address_i(mxa), .abort_i(abort), .ext_xchg_i(exx),
		.busy_o(busy), .mode_monitor_flag_o(mf), .done_o(done), .next_p_o(np),
		.next_parcel_o(npar), .wb_valid_o(wbv), .wb_idx_o(wbi), .wb_data_o(wbd),
		.err_valid_o(errv), .err_code_o(errc), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_ext_o(mext), .mem_addr_o(madr), .mem_wdata_o(mwd), .mem_ack_i(mack),
		.mem_rdata_i(mrd), .xchg_req_o(xreq), .xchg_addr_o(xadr), .xchg_save_p_o(xsp),
		.xchg_ack_i(xack), .xchg_p_i(xp));
	cpx_mem_model PART (.clk_i(clk), .mem_req_i(mreq), .mem_we_i(mwe), .mem_ext_i(mext),
		.mem_addr_i(madr), .mem_wdata_i(mwd), .xchg_req_i(xreq), .mem_ack_o(mack),
		.mem_rdata_o(mrd), .xchg_ack_o(xack), .xchg_p_o(xp));
	task automatic print_verdict();
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		radr <= a;
		rwd <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		radr <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	// Unused low parcels carry a pattern so that stray decoding shows up.
	function automatic logic [59:0] w2(input logic [8:0] op, input logic [2:0] j,
		input logic [17:0] k);
		return {op, j, k, 30'h2AAA_AAAA};
	endfunction
	task automatic go(input logic [59:0] w, input logic [1:0] p);
		@(posedge clk);
		iw <= w;
		par <= p;
		iv <= 1'b1;
		@(posedge clk);
		iv <= 1'b0;
		t0 = cyc;
		hit = 3'b000;
		for (int i = 0; i < 300 && hit == 3'b000; i++) begin
			#1 hit = {done, errv, wbv};
			if (hit == 3'b000) @(posedge clk);
		end
	endtask
	initial begin
		wait (!srst);
		rdchk(4'h0, 32'h0000_0000);
		rdchk(4'h4, 32'h0000_0001);
		rdchk(4'h8, 32'h0000_0000);
		wr(4'h0, 32'h0000_0009);
		go(w2(9'h007, 3'd7, 18'h3_FFFF), 2'd0);
		`CHK(hit, 3'b100)
		wr(4'h0, 32'h0000_000D);
		rdchk(4'h0, 32'h0000_000D);
		go(w2(9'h007, 3'd7, 18'h3_FFFF), 2'd0);
		`CHK(errc, CPX_ERR_VIRTUAL)
		go(w2(9'h00E, 3'd3, 18'h2_8000), 2'd0);
		c1 = wbd;
		t1 = t0;
		repeat (5) @(posedge clk);
		go(w2(9'h00E, 3'd3, 18'h2_8000), 2'd0);
		`CHK(wbd[59:48], 12'h000)
		`CHK(wbi, 3'd3)
		`CHK(wbd[47:0] - c1[47:0], 48'(t0 - t1))
		PART.lat = 2;
		go(w2(9'h008, 3'd7, 18'h0_0200), 2'd0);
		`CHK(PART.cmem[32'h1200], {12'h100, 18'h0_0101, 30'h0})
		`CHK({np, npar}, {18'h0_0201, 2'd0})
		for (int i = 0; i < 4; i++) PART.emem[32'h1_0020 + i] = 60'(i + 5);
		x0 = 60'h20;
		bj = 18'h0_0002;
		go(w2(9'h009, 3'd2, 18'h0_0001), 2'd0);
		`CHK({np, npar}, {pa + 18'h0_0001, 2'd0})
		for (int i = 0; i < 3; i++) `CHK(PART.cmem[32'h1300 + i], 60'(i + 5))
		`CHK(PART.cmem.exists(32'h1303), 0)
		x0 = 60'h40;
		bj = 18'h0_0001;
		go(w2(9'h00A, 3'd1, 18'h0_0001), 2'd0);
		for (int i = 0; i < 3; i++) `CHK(PART.emem.exists(32'h1_0040 + i), i < 2)
		`CHK(PART.emem[32'h1_0041], 60'h6)
		`CHK({np, npar}, {pa + 18'h0_0001, 2'd0})
		x0 = 60'h20_0000;
		bj = 18'h0;
		go(w2(9'h009, 3'd0, 18'h0_0001), 2'd0);
		`CHK(PART.cmem[32'h1300], 60'h0)
		`CHK({np, npar}, {pa, 2'd2})
		x0 = 60'h40_0000;
		go(w2(9'h00A, 3'd0, 18'h0_0001), 2'd0);
		`CHK(PART.emem.exists(32'h41_0000), 0)
		`CHK({np, npar}, {pa, 2'd2})
		x0 = 60'h140_0000_0020;
		wr(4'h0, 32'h0000_000F);
		go(w2(9'h009, 3'd0, 18'h0_0001), 2'd0);
		`CHK(PART.cmem[32'h1500], 60'h5)
		wr(4'h0, 32'h0000_000D);
		x0 = 60'h80;
		for (int i = 0; i < 2; i++) begin
			bj = i ? 18'h3_FFFF : 18'h0;
			go(w2(9'h009, 3'd0, 18'h0), 2'd0);
			`CHK({hit, np, npar}, {3'b100, pa + 18'h0_0001, 2'd0})
		end
		bj = 18'h3_FFFE;
		go(w2(9'h009, 3'd0, 18'h0), 2'd0);
		`CHK({hit, errc}, {3'b010, CPX_ERR_RANGE})
		bj = 18'h0_0001;
		go(w2(9'h009, 3'd1, 18'h0_0001) >> 15, 2'd1);
		`CHK(hit, 3'b010)
		wr(4'h0, 32'h0000_000C);
		go(w2(9'h009, 3'd1, 18'h0_0001), 2'd0);
		`CHK(hit, 3'b010)
		go(w2(9'h00C, 3'd4, 18'h1_8000), 2'd0);
		`CHK(hit, 3'b010)
		go(w2(9'h00D, 3'd4, 18'h1_8000), 2'd0);
		`CHK(hit, 3'b010)
		wr(4'h0, 32'h0000_000D);
		xk = 60'h5;
		PART.emem[32'h1_0005] = 60'h123;
		go(w2(9'h00C, 3'd4, 18'h1_8000), 2'd0);
		`CHK({wbd, wbi}, {60'h123, 3'd4})
		xk = 60'h6;
		xj = 60'h456;
		go(w2(9'h00D, 3'd4, 18'h1_8000), 2'd0);
		`CHK(PART.emem[32'h1_0006], 60'h456)
		bj = 18'h0_0010;
		PART.new_p = 18'h0_0777;
		go(w2(9'h00B, 3'd1, 18'h0_0020), 2'd0);
		`CHK({xa, xs}, {24'h00_0030, pa + 18'h0_0001})
		`CHK({np, npar, mf}, {18'h0_0777, 2'd0, 1'b0})
		go(w2(9'h00B, 3'd1, 18'h0_0020), 2'd0);
		`CHK({xa, mf}, {24'h00_0ABC, 1'b1})
		@(posedge clk);
		exx <= 1'b1;
		@(posedge clk);
		exx <= 1'b0;
		#1 `CHK(mf, 1'b0)
		go(w2(9'h007, 3'd7, 18'h3_FFFF), 2'd0);
		`CHK({hit, errc}, {3'b010, CPX_ERR_ILLEGAL})
		PART.lat = 6;
		x0 = 60'h20;
		bj = 18'h0_0002;
		fork
			go(w2(9'h009, 3'd2, 18'h0_0001), 2'd0);
			begin
				repeat (8) @(posedge clk);
				abort <= 1'b1;
				#1 `CHK(busy, 1'b1)
			end
		join
		abort <= 1'b0;
		`CHK({np, npar}, {pa, 2'd0})
		print_verdict();
	end
endmodule
